// ==== pmor_flag_if.sv ====
// Temperature flags and forced switch-off requests between submodule and top
`timescale 1ns/1ns
interface pmor_flag_if;
    logic charge_cold_flag;
    logic charge_hot_flag;
    logic discharge_cold_flag;
    logic discharge_hot_flag;
    logic charge_off;
    logic discharge_off;
    modport src (output charge_cold_flag, charge_hot_flag, discharge_cold_flag,
                 discharge_hot_flag, charge_off, discharge_off);
    modport dst (input charge_cold_flag, charge_hot_flag, discharge_cold_flag,
                 discharge_hot_flag, charge_off, discharge_off);
endinterface

// ==== pmor_host.sv ====
// Host controller model driving the decoded register byte port
`timescale 1ns/1ns
module pmor_host (
    input wire logic clk,
    output logic [pmor_pkg::ADDR_W-1:0] reg_addr,
    output logic [pmor_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [pmor_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    import pmor_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
    end
    function automatic logic is_rsv(input logic [ADDR_W-1:0] a);
        return (a >= RSV_LO) && (a <= RSV_HI);
    endfunction
    // Released lines carry the inverse so stale values never pass
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        if (!is_rsv(a)) begin
            @(posedge clk);
            #1;
            reg_addr = a;
            reg_wdata = d;
            reg_we = 1'b1;
            @(posedge clk);
            #1;
            reg_we = 1'b0;
            reg_addr = ~a;
            reg_wdata = ~d;
        end
    endtask
    // Each read drops reg_re 1 ns past the taking edge; the next access waits for a further edge, giving the idle gap
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
        d = 8'h00;
        ok = 1'b0;
        if (!is_rsv(a)) begin
            @(posedge clk);
            #1;
            reg_addr = a;
            reg_re = 1'b1;
            @(posedge clk);
            #1;
            reg_re = 1'b0;
            reg_addr = ~a;
            ok = reg_rvalid;
            d = reg_rdata;
        end
    endtask
endmodule // pmor_host

// ==== pmor_pkg.sv ====
// Constants shared by the pack monitor operations register bank
// What this block does
// - 0x50 to 0x57 is plain user storage
// - Operations registers are volatile, no backing store
// - Power-on reset loads every operations register zero
// - Writable bits let host override internal control
// - Fault status read-only, set and cleared internally
// - Charge cold flag sets above its voltage
// - Charge cold plus charge current forces off
// - Charge cold flag clears below recovery voltage
// - Charge hot flag sets below its voltage
// - Charge hot plus charge current forces off
// - Charge hot flag clears above recovery voltage
// - Discharge cold flag sets above its voltage
// - Discharge cold plus discharge current forces off
// - Discharge cold flag clears below recovery
// - One host bit per cell balance switch
// - Discharge hot flag plus discharge current forces discharge switch off
package pmor_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int TEMP_W = 12;
    localparam int CUR_W = 2;
    localparam logic [ADDR_W-1:0] RSV_LO = 8'h4C;
    localparam logic [ADDR_W-1:0] RSV_HI = 8'h4F;
    localparam logic [ADDR_W-1:0] USER_LO = 8'h50;
    localparam logic [ADDR_W-1:0] USER_HI = 8'h57;
    localparam int USER_DEPTH = 8;
    localparam logic [ADDR_W-1:0] FAULT_PRI_ADDR = 8'h80;
    localparam logic [ADDR_W-1:0] FAULT_SEC_ADDR = 8'h81;
    localparam logic [ADDR_W-1:0] ACTIVITY_ADDR = 8'h82;
    localparam logic [ADDR_W-1:0] PWR_BAL_ADDR = 8'h83;
    localparam logic [ADDR_W-1:0] BAL_CTRL_ADDR = 8'h84;
    localparam logic [ADDR_W-1:0] MEAS_CTRL_ADDR = 8'h85;
    localparam logic [ADDR_W-1:0] OUT_CTRL_ADDR = 8'h86;
    localparam logic [ADDR_W-1:0] OVR_CTRL_ADDR = 8'h87;
    localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = 8'h88;
    localparam logic [ADDR_W-1:0] NVM_EN_ADDR = 8'h89;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MEAS_MASK = 8'h7F;
    localparam logic [DATA_W-1:0] OUT_MASK = 8'hFF;
    localparam logic [DATA_W-1:0] OVR_MASK = 8'h7F;
    localparam logic [DATA_W-1:0] PWR_MASK = 8'h0F;
    localparam logic [DATA_W-1:0] NVM_MASK = 8'h01;
    // Flag positions in fault_status_primary
    localparam int CCOLD_BIT = 7;
    localparam int CHOT_BIT = 6;
    localparam int DCOLD_BIT = 5;
    localparam int DHOT_BIT = 4;
    // activity_status positions
    localparam int DSEEN_BIT = 3;
    localparam int CSEEN_BIT = 2;
    // output_switch_control positions
    localparam int OUT_CSW_BIT = 1;
    localparam int OUT_DSW_BIT = 0;
    // host_override_control position
    localparam int OVR_SW_BIT = 6;
    // Current sense vector positions
    localparam int CUR_CHG = 0;
    localparam int CUR_DCH = 1;
    typedef enum {PMOR_IDLE, PMOR_READ} pmor_rd_state_t;
endpackage

// ==== pmor_regs.sv ====
// Operations register bank of the pack monitor with temperature fault control
`timescale 1ns/1ns
module pmor_regs (
    input wire logic clk,
    input wire logic rstn,
    // Decoded byte access from the two-wire serial front end
    input wire logic [pmor_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [pmor_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [pmor_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // Thermistor sample, same clock as this block
    input wire logic temp_valid,
    input wire logic [pmor_pkg::TEMP_W-1:0] temp_v,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_cold_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_cold_recovery,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_hot_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_hot_recovery,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_cold_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_cold_recovery,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_hot_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_hot_recovery,
    // Current direction comparators, asynchronous
    input wire logic charge_current_seen,
    input wire logic discharge_current_seen,
    output logic charge_switch,
    output logic discharge_switch,
    output logic [pmor_pkg::DATA_W-1:0] balance_switch_bits,
    output logic nvm_enable_bit
);
    import pmor_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Submodules

    logic [CUR_W-1:0] cur_seen;
    pmor_flag_if flg ();

    pmor_sync #(
        .W(CUR_W)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in({discharge_current_seen, charge_current_seen}),
        .sync_out(cur_seen)
    );

    pmor_temp_fault u_temp (
        .clk(clk),
        .rstn(rstn),
        .temp_valid(temp_valid),
        .temp_v(temp_v),
        .charge_cold_threshold(charge_cold_threshold),
        .charge_cold_recovery(charge_cold_recovery),
        .charge_hot_threshold(charge_hot_threshold),
        .charge_hot_recovery(charge_hot_recovery),
        .discharge_cold_threshold(discharge_cold_threshold),
        .discharge_cold_recovery(discharge_cold_recovery),
        .discharge_hot_threshold(discharge_hot_threshold),
        .discharge_hot_recovery(discharge_hot_recovery),
        .cur_seen(cur_seen),
        .flags(flg.src)
    );

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] target);
        hit = (a == target);
    endfunction

    function automatic logic in_user(input logic [ADDR_W-1:0] a);
        in_user = (a >= USER_LO) && (a <= USER_HI);
    endfunction

    logic wr_bal, wr_meas, wr_out, wr_ovr, wr_pwr, wr_nvm, wr_user;

    // Status addresses and the reserved window have no write decode
    assign wr_bal = reg_we && hit(reg_addr, BAL_CTRL_ADDR);
    assign wr_meas = reg_we && hit(reg_addr, MEAS_CTRL_ADDR);
    assign wr_out = reg_we && hit(reg_addr, OUT_CTRL_ADDR);
    assign wr_ovr = reg_we && hit(reg_addr, OVR_CTRL_ADDR);
    assign wr_pwr = reg_we && hit(reg_addr, PWR_CTRL_ADDR);
    assign wr_nvm = reg_we && hit(reg_addr, NVM_EN_ADDR);
    assign wr_user = reg_we && in_user(reg_addr);

    ////////////////////////////////////////////////////////////////////////
    // Writable control registers, volatile, zero at power-on

    logic [DATA_W-1:0] bal_q;
    logic [DATA_W-1:0] meas_q;
    logic [DATA_W-1:0] out_q;
    logic [DATA_W-1:0] ovr_q;
    logic [DATA_W-1:0] pwr_q;
    logic [DATA_W-1:0] nvm_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bal_q <= REG_RESET;
        end else if (wr_bal) begin
            bal_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meas_q <= REG_RESET;
            out_q <= REG_RESET;
            ovr_q <= REG_RESET;
            pwr_q <= REG_RESET;
            nvm_q <= REG_RESET;
        end else begin
            // Reserved bits are masked so they always read back zero
            if (wr_meas) begin
                meas_q <= reg_wdata & MEAS_MASK;
            end
            if (wr_out) begin
                out_q <= reg_wdata & OUT_MASK;
            end
            if (wr_ovr) begin
                ovr_q <= reg_wdata & OVR_MASK;
            end
            if (wr_pwr) begin
                pwr_q <= reg_wdata & PWR_MASK;
            end
            if (wr_nvm) begin
                nvm_q <= reg_wdata & NVM_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User storage window; plain bytes with no side effects

    logic [DATA_W-1:0] user_mem [USER_DEPTH];
    logic [2:0] user_idx;

    assign user_idx = reg_addr[2:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 0; k < USER_DEPTH; k++) begin
                user_mem[k] <= REG_RESET;
            end
        end else if (wr_user) begin
            user_mem[user_idx] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status registers, driven by the device except pwr_bal bits 6:4, which echo host-written pwr_q

    logic [DATA_W-1:0] fault_pri;
    logic [DATA_W-1:0] activity;
    logic [DATA_W-1:0] pwr_bal;

    always_comb begin
        fault_pri = REG_RESET;
        fault_pri[CCOLD_BIT] = flg.charge_cold_flag;
        fault_pri[CHOT_BIT] = flg.charge_hot_flag;
        fault_pri[DCOLD_BIT] = flg.discharge_cold_flag;
        fault_pri[DHOT_BIT] = flg.discharge_hot_flag;
        activity = REG_RESET;
        activity[DSEEN_BIT] = cur_seen[CUR_DCH];
        activity[CSEEN_BIT] = cur_seen[CUR_CHG];
        // Power state bits 2:0 echoed in bits 6:4, balance faults not modelled
        pwr_bal = REG_RESET;
        pwr_bal[6:4] = pwr_q[2:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: one-cycle registered answer

    logic [DATA_W-1:0] rd_d;
    logic [DATA_W-1:0] rdata_q;
    logic rvalid_q;
    pmor_rd_state_t rd_state_q;

    always_comb begin
        rd_d = REG_RESET;
        if (in_user(reg_addr)) begin
            rd_d = user_mem[user_idx];
        end else begin
            case (reg_addr)
                FAULT_PRI_ADDR: rd_d = fault_pri;
                FAULT_SEC_ADDR: rd_d = REG_RESET;
                ACTIVITY_ADDR: rd_d = activity;
                PWR_BAL_ADDR: rd_d = pwr_bal;
                BAL_CTRL_ADDR: rd_d = bal_q;
                MEAS_CTRL_ADDR: rd_d = meas_q;
                OUT_CTRL_ADDR: rd_d = out_q;
                OVR_CTRL_ADDR: rd_d = ovr_q;
                PWR_CTRL_ADDR: rd_d = pwr_q;
                NVM_EN_ADDR: rd_d = nvm_q;
                // Reserved window and unmapped bytes read zero
                default: rd_d = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_state_q <= PMOR_IDLE;
            rdata_q <= REG_RESET;
            rvalid_q <= 1'b0;
        end else begin
            case (rd_state_q)
                PMOR_IDLE: begin
                    rvalid_q <= reg_re;
                    if (reg_re) begin
                        rdata_q <= rd_d;
                        rd_state_q <= PMOR_READ;
                    end
                end
                PMOR_READ: begin
                    rvalid_q <= 1'b0;
                    rd_state_q <= PMOR_IDLE;
                end
                default: begin
                    rvalid_q <= 1'b0;
                    rd_state_q <= PMOR_IDLE;
                end
            endcase
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    ////////////////////////////////////////////////////////////////////////
    // Power switches and balance outputs

    logic csw_q, dsw_q;
    logic host_sw;

    assign host_sw = ovr_q[OVR_SW_BIT];

    // Host override bypasses the fault response; that is its purpose
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csw_q <= 1'b0;
            dsw_q <= 1'b0;
        end else if (host_sw) begin
            csw_q <= out_q[OUT_CSW_BIT];
            dsw_q <= out_q[OUT_DSW_BIT];
        end else begin
            csw_q <= !flg.charge_off;
            dsw_q <= !flg.discharge_off;
        end
    end

    assign charge_switch = csw_q;
    assign discharge_switch = dsw_q;
    assign balance_switch_bits = bal_q;
    assign nvm_enable_bit = nvm_q[0];

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence read_req_s;
        reg_re && rd_state_q == PMOR_IDLE;
    endsequence

    sequence answer_s;
        reg_rvalid ##1 !reg_rvalid;
    endsequence

    read_answer_a: assert property (@(posedge clk) disable iff (!rstn)
        read_req_s |=> answer_s)
        else $error("read answer not one cycle pulse");
    status_ro_a: assert property (@(posedge clk) disable iff (!rstn)
        (read_req_s and (reg_addr == FAULT_PRI_ADDR)) |=>
        reg_rdata[CCOLD_BIT] == $past(flg.charge_cold_flag))
        else $error("fault status read mismatch");
    // Covers the reserved window and every unmapped byte below the status bank
    rsv_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        (read_req_s and (!in_user(reg_addr) && reg_addr < FAULT_PRI_ADDR)) |=>
        reg_rdata == REG_RESET)
        else $error("reserved window read nonzero");
    ovr_rsv_a: assert property (@(posedge clk) disable iff (!rstn)
        ovr_q[7] == 1'b0 && pwr_q[7:4] == 4'h0 && nvm_q[7:1] == 7'h00)
        else $error("reserved control bit set");
    cold_off_a: assert property (@(posedge clk) disable iff (!rstn)
        !host_sw && flg.charge_cold_flag && cur_seen[CUR_CHG] |=> !charge_switch)
        else $error("charge switch not forced off");
    dcold_off_a: assert property (@(posedge clk) disable iff (!rstn)
        !host_sw && flg.discharge_cold_flag && cur_seen[CUR_DCH]
        |=> !discharge_switch)
        else $error("discharge switch not forced off");
    host_sw_a: assert property (@(posedge clk) disable iff (!rstn)
        host_sw |=> charge_switch == $past(out_q[OUT_CSW_BIT]))
        else $error("host override not followed");
    bal_write_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_bal |=> balance_switch_bits == $past(reg_wdata))
        else $error("balance bits not written");
    user_rd_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_user ##1 !reg_we ##1 (read_req_s and (reg_addr == $past(reg_addr, 2)))
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("user byte not stored");
endmodule // pmor_regs

// ==== pmor_sync.sv ====
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module pmor_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta_q[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate
endmodule // pmor_sync

// ==== pmor_temp_fault.sv ====
// Thermistor comparisons and temperature fault flags
`timescale 1ns/1ns
module pmor_temp_fault (
    input wire logic clk,
    input wire logic rstn,
    input wire logic temp_valid,
    input wire logic [pmor_pkg::TEMP_W-1:0] temp_v,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_cold_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_cold_recovery,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_hot_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] charge_hot_recovery,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_cold_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_cold_recovery,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_hot_threshold,
    input wire logic [pmor_pkg::TEMP_W-1:0] discharge_hot_recovery,
    input wire logic [pmor_pkg::CUR_W-1:0] cur_seen,
    pmor_flag_if.src flags
);
    import pmor_pkg::*;

    // Set wins over clear when both comparisons hold on a bad threshold pair
    function automatic logic hyst(input logic cur, input logic set_c, input logic clr_c);
        hyst = set_c ? 1'b1 : (clr_c ? 1'b0 : cur);
    endfunction

    logic ccold_q, chot_q, dcold_q, dhot_q;

    // NTC: colder means higher sensed voltage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ccold_q <= 1'b0;
            chot_q <= 1'b0;
            dcold_q <= 1'b0;
            dhot_q <= 1'b0;
        end else if (temp_valid) begin
            ccold_q <= hyst(ccold_q, temp_v > charge_cold_threshold,
                            temp_v < charge_cold_recovery);
            chot_q <= hyst(chot_q, temp_v < charge_hot_threshold,
                           temp_v > charge_hot_recovery);
            dcold_q <= hyst(dcold_q, temp_v > discharge_cold_threshold,
                            temp_v < discharge_cold_recovery);
            dhot_q <= hyst(dhot_q, temp_v < discharge_hot_threshold,
                           temp_v > discharge_hot_recovery);
        end
    end

    assign flags.charge_cold_flag = ccold_q;
    assign flags.charge_hot_flag = chot_q;
    assign flags.discharge_cold_flag = dcold_q;
    assign flags.discharge_hot_flag = dhot_q;
    // Direction picks which flag pair governs each switch
    assign flags.charge_off = (ccold_q | chot_q) & cur_seen[CUR_CHG];
    assign flags.discharge_off = (dcold_q | dhot_q) & cur_seen[CUR_DCH];

    ccold_set_a: assert property (@(posedge clk) disable iff (!rstn)
        temp_valid && temp_v > charge_cold_threshold |=> ccold_q)
        else $error("charge cold flag not set");
    ccold_clr_a: assert property (@(posedge clk) disable iff (!rstn)
        temp_valid && temp_v < charge_cold_recovery
        && !(temp_v > charge_cold_threshold) |=> !ccold_q)
        else $error("charge cold flag not cleared");
    chot_set_a: assert property (@(posedge clk) disable iff (!rstn)
        temp_valid && temp_v < charge_hot_threshold |=> chot_q)
        else $error("charge hot flag not set");
    chot_clr_a: assert property (@(posedge clk) disable iff (!rstn)
        temp_valid && temp_v > charge_hot_recovery
        && !(temp_v < charge_hot_threshold) |=> !chot_q)
        else $error("charge hot flag not cleared");
    dcold_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        !temp_valid |=> $stable(dcold_q))
        else $error("discharge cold flag moved without a sample");
    dhot_set_a: assert property (@(posedge clk) disable iff (!rstn)
        temp_valid && temp_v < discharge_hot_threshold |=> dhot_q)
        else $error("discharge hot flag not set");
endmodule // pmor_temp_fault

// ==== tb.sv ====
// Self-checking testbench of the operations register bank
`timescale 1ns/1ns
module tb;
    import pmor_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [DATA_W-1:0] reg_rdata;
    logic reg_rvalid;
    logic temp_valid = 1'b0;
    logic [TEMP_W-1:0] temp_v = 12'h800;
    logic [TEMP_W-1:0] thr [8] = '{12'hC00, 12'hB00, 12'h300, 12'h400,
                                   12'hD00, 12'hC80, 12'h200, 12'h280};
    logic charge_current_seen = 1'b0;
    logic discharge_current_seen = 1'b0;
    logic charge_switch;
    logic discharge_switch;
    logic [DATA_W-1:0] balance_switch_bits;
    logic nvm_enable_bit;
    int mismatches = 0;
    int check_count = 0;
    always #50 clk = ~clk;
    pmor_host u_pmor_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    pmor_regs u_pmor_regs (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .temp_valid(temp_valid), .temp_v(temp_v),
        .charge_cold_threshold(thr[0]), .charge_cold_recovery(thr[1]),
        .charge_hot_threshold(thr[2]), .charge_hot_recovery(thr[3]),
        .discharge_cold_threshold(thr[4]), .discharge_cold_recovery(thr[5]),
        .discharge_hot_threshold(thr[6]), .discharge_hot_recovery(thr[7]),
        .charge_current_seen(charge_current_seen),
        .discharge_current_seen(discharge_current_seen), .charge_switch(charge_switch),
        .discharge_switch(discharge_switch), .balance_switch_bits(balance_switch_bits),
        .nvm_enable_bit(nvm_enable_bit));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Answer flag joins the data so a missing answer also fails
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] d;
        logic ok;
        u_pmor_host.rd(a, d, ok);
        chk({7'h00, ok, d}, {8'h01, e});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int a = 8'h80; a <= 8'h89; a++) begin
            rdchk(a[7:0], 8'h00);
        end
        chk({14'h0, charge_switch, discharge_switch}, 16'h0003);
    endtask
    task automatic t_regs();
        logic [7:0] wa [9] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h80, 8'h81, 8'h60};
        logic [7:0] wm [9] = '{8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'h0F, 8'h01, 8'h00, 8'h00, 8'h00};
        u_pmor_host.wr(BAL_CTRL_ADDR, 8'hA5);
        chk({8'h00, balance_switch_bits}, 16'h00A5);
        for (int i = 0; i < 9; i++) begin
            u_pmor_host.wr(wa[i], 8'hFF);
            rdchk(wa[i], wm[i]);
        end
        rdchk(PWR_BAL_ADDR, 8'h70);
        chk({15'h0, nvm_enable_bit}, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            u_pmor_host.wr(USER_LO + 8'(i), 8'(8'h11 * i));
            rdchk(USER_LO + 8'(i), 8'(8'h11 * i));
        end
        for (int i = 0; i < 8; i++) begin
            rdchk(USER_LO + 8'(i), 8'(8'h11 * i));
        end
        // Override set: switches follow the host bits only
        u_pmor_host.wr(OUT_CTRL_ADDR, 8'h02);
        repeat (2) @(posedge clk);
        #1;
        chk({14'h0, charge_switch, discharge_switch}, 16'h0002);
        u_pmor_host.wr(OUT_CTRL_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        chk({14'h0, charge_switch, discharge_switch}, 16'h0001);
        u_pmor_host.wr(OVR_CTRL_ADDR, 8'h00);
        u_pmor_host.wr(OUT_CTRL_ADDR, 8'h00);
        u_pmor_host.wr(PWR_CTRL_ADDR, 8'h00);
    endtask
    // Walks set and clear for all four flags, hold within hysteresis for the two charge flags
    task automatic t_temp(input logic [TEMP_W-1:0] off);
        logic [11:0] tv [9] = '{12'h800, 12'hC80, 12'hB80, 12'hE00, 12'hA00,
                                12'h250, 12'h380, 12'h100, 12'h500};
        logic [1:0] cur [9] = '{2'b00, 2'b01, 2'b01, 2'b10, 2'b00, 2'b01, 2'b01, 2'b10, 2'b00};
        logic [7:0] fl [9] = '{8'h00, 8'h80, 8'h80, 8'hA0, 8'h00, 8'h40, 8'h40, 8'h50, 8'h00};
        logic [1:0] sw [9] = '{2'b11, 2'b01, 2'b01, 2'b10, 2'b11, 2'b01, 2'b01, 2'b10, 2'b11};
        logic [11:0] base [8] = '{12'hC00, 12'hB00, 12'h300, 12'h400,
                                  12'hD00, 12'hC80, 12'h200, 12'h280};
        @(posedge clk);
        #1;
        for (int k = 0; k < 8; k++) begin
            thr[k] = base[k] + off;
        end
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            #1;
            charge_current_seen = cur[i][0];
            discharge_current_seen = cur[i][1];
            temp_v = tv[i] + off;
            temp_valid = 1'b1;
            @(posedge clk);
            #1;
            temp_valid = 1'b0;
            // Current inputs pass a two-flop synchroniser first
            repeat (5) @(posedge clk);
            #1;
            chk({14'h0, charge_switch, discharge_switch}, {14'h0, sw[i]});
            rdchk(FAULT_PRI_ADDR, fl[i]);
            rdchk(ACTIVITY_ADDR, {4'h0, cur[i], 2'b00});
        end
    endtask
    task automatic t_mid_reset();
        u_pmor_host.wr(BAL_CTRL_ADDR, 8'h3C);
        @(posedge clk);
        #1;
        rstn = 1'b0;
        repeat (2) @(posedge clk);
        chk({8'h00, balance_switch_bits}, 16'h0000);
        #1;
        rstn = 1'b1;
        rdchk(BAL_CTRL_ADDR, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2000000;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_regs();
        t_temp(12'h000);
        t_temp(12'h010);
        t_mid_reset();
        give_verdict();
    end
endmodule // tb
